// ===== verilog/pin_cfg_pkg.sv
/*
  Constants for the run-time settings image and pin mux block.
  Assumes a single 100 MHz clock and an active-low asynchronous reset.
*/
package pin_cfg_pkg;
  // ----------------------------------------
  // response framing
  // ----------------------------------------
  localparam logic [7:0] ECHO_CODE = 8'h61;
  localparam logic [7:0] STATUS_OK = 8'h00;
  localparam logic [5:0] RESP_LAST = 6'h3F;
  localparam logic [5:0] IDX_CHIP = 6'h07;
  localparam logic [5:0] IDX_VID_LO = 6'h08;
  localparam logic [5:0] IDX_VID_HI = 6'h09;
  localparam logic [5:0] IDX_PID_LO = 6'h0A;
  localparam logic [5:0] IDX_PID_HI = 6'h0B;
  localparam logic [5:0] IDX_PWR_ATTR = 6'h0C;
  localparam logic [5:0] IDX_CURRENT = 6'h0D;
  localparam logic [5:0] IDX_PWD_FIRST = 6'h0E;
  localparam logic [5:0] IDX_PWD_LAST = 6'h15;
  localparam logic [5:0] IDX_PIN0 = 6'h16;
  localparam logic [5:0] IDX_PIN1 = 6'h17;
  localparam logic [5:0] IDX_PIN2 = 6'h18;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int NEG_EDGE_BIT = 6;
  localparam int POS_EDGE_BIT = 5;
  localparam int VREF_LVL_HI = 4;
  localparam int VREF_LVL_LO = 3;
  localparam int VREF_OPT_BIT = 2;
  localparam int OUT_VAL_BIT = 4;
  localparam int DIR_BIT = 3;
  localparam logic [7:0] CHIP_MASK = 8'h7C;
  localparam logic [7:0] PIN_MASK = 8'h1F;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CHIP_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h08;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // ----------------------------------------
  // designation codes
  // ----------------------------------------
  localparam logic [2:0] DES_GPIO = 3'h0;
  localparam logic [2:0] DES_ALT_DED = 3'h1;
  localparam logic [2:0] DES_ALT0 = 3'h2;
  localparam logic [2:0] DES_ALT1 = 3'h3;
  localparam logic [2:0] DES_ALT2 = 3'h4;
  typedef enum logic [1:0] {VREF_OFF, VREF_1V024, VREF_2V048, VREF_4V096} vref_lvl_t;
  typedef enum {RD_IDLE, RD_SEND} rd_state_t;
endpackage : pin_cfg_pkg

// ===== verilog/edge_detect.sv
/*
  Interrupt edge detector: synchronises the detection input and raises
  a sticky flag on the enabled edges. Assumes the input is asynchronous.
*/
module edge_detect
  import pin_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire logic neg_en,
  input wire logic pos_en,
  input wire logic active,
  // pin and flag
  input wire logic pin_in,
  input wire logic flag_clr,
  output logic flag
);
  logic s1_r, s2_r, s3_r;
  logic flag_r, flag_nxt;

  always_comb
  begin
    flag_nxt = flag_r;
    if (flag_clr)
    begin
      flag_nxt = 1'b0;
    end
    // edge sets flag, set wins over clear
    if (active && ((neg_en && s3_r && !s2_r) || (pos_en && !s3_r && s2_r)))
    begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      flag_r <= 1'b0;
    end
    else
    begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      flag_r <= flag_nxt;
    end
  end

  assign flag = flag_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_neg_edge;
    @(posedge clk) disable iff (!nrst)
      (active && neg_en && s3_r && !s2_r) |=> flag_r;
  endproperty
  a_neg_edge: assert property (p_neg_edge) else $error("falling edge missed");
  property p_pos_edge;
    @(posedge clk) disable iff (!nrst)
      (active && pos_en && !s3_r && s2_r) |=> flag_r;
  endproperty
  a_pos_edge: assert property (p_pos_edge) else $error("rising edge missed");
  property p_no_spurious;
    @(posedge clk) disable iff (!nrst)
      (!flag_r && !(active && (neg_en || pos_en))) |=> !flag_r;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("flag set with edges disabled");
  c_flag: cover property (@(posedge clk) disable iff (!nrst) !flag_r ##1 flag_r);
endmodule : edge_detect

// ===== verilog/runtime_settings_pin_config.sv
/*
  Run-time settings image with pin mux for three general-purpose pins.
  Host command decoding is outside: it asks for readback with rd_req and
  loads the image with the wr_* strobes. Pins are driven through enables.
*/
module runtime_settings_pin_config
  import pin_cfg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // settings load
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire logic [7:0] wr_data,
  // readback
  input wire logic rd_req,
  output logic rd_valid,
  output logic [5:0] rd_idx,
  output logic [7:0] rd_data,
  // alternate function sources
  input wire logic suspend_in,
  input wire logic uart_rx_act,
  input wire logic uart_tx_act,
  input wire logic clk_out_in,
  input wire logic usb_cfg_in,
  input wire logic flag_clr,
  // analog and usb configuration
  output logic [1:0] vref_level,
  output logic vref_internal,
  output logic [15:0] usb_vid,
  output logic [15:0] usb_pid,
  output logic [7:0] usb_power_attr,
  output logic [8:0] usb_current_ma,
  output logic int_flag,
  output logic [2:0] analog_sel,
  // pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic [2:0] gpio_in_val
);
  logic [7:0] img_r [7:24];
  logic [7:0] img_nxt [7:24];
  rd_state_t st_r, st_nxt;
  logic [5:0] idx_r, idx_nxt;
  logic [7:0] data_nxt;
  logic [2:0] out_nxt, oe_nxt, ana_nxt;
  logic [2:0] p1_r, p2_r;
  logic flag_w;
  default clocking chk_cb @(posedge clk); endclocking
  default disable iff (!nrst);
  function automatic logic [7:0] masked(input logic [5:0] i, input logic [7:0] v);
    masked = v;
    if (i == IDX_CHIP)
    begin
      masked = v & CHIP_MASK;
    end
    else if (i >= IDX_PIN0 && i <= IDX_PIN2)
    begin
      masked = v & PIN_MASK;
    end
  endfunction : masked
  // ----------------------------------------
  // settings image
  // ----------------------------------------
  always_comb
  begin
    img_nxt = img_r;
    if (wr_en && wr_idx >= IDX_CHIP && wr_idx <= IDX_PIN2)
    begin
      img_nxt[wr_idx] = masked(wr_idx, wr_data);
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = int'(IDX_CHIP); i <= int'(IDX_PIN2); i++)
      begin
        img_r[i] <= (i >= int'(IDX_PIN0)) ? PIN_RST : ((i == int'(IDX_CHIP)) ? CHIP_RST : BYTE_RST);
      end
    end
    else
    begin
      img_r <= img_nxt;
    end
  end
  // ----------------------------------------
  // readback sequencer
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    data_nxt = 8'h00;
    unique case (st_r)
      RD_IDLE:
      begin
        if (rd_req)
        begin
          st_nxt = RD_SEND;
          idx_nxt = 6'h00;
        end
      end
      RD_SEND:
      begin
        idx_nxt = 6'(idx_r + 6'h01);
        if (idx_r == RESP_LAST)
        begin
          st_nxt = RD_IDLE;
          idx_nxt = 6'h00;
        end
      end
    endcase
    if (st_nxt == RD_SEND && idx_nxt == 6'h00)
    begin
      data_nxt = ECHO_CODE;
    end
    else if (st_nxt == RD_SEND && idx_nxt == 6'h01)
    begin
      data_nxt = STATUS_OK;
    end
    else if (st_nxt == RD_SEND && idx_nxt >= IDX_CHIP && idx_nxt <= IDX_PIN2)
    begin
      data_nxt = masked(idx_nxt, img_r[idx_nxt]);
    end
  end

  // ----------------------------------------
  // pin mux
  // ----------------------------------------
  always_comb
  begin
    out_nxt = 3'h0;
    oe_nxt = 3'h0;
    ana_nxt = 3'h0;
    for (int p = 0; p < 3; p++)
    begin
      if (img_r[IDX_PIN0 + p][2:0] == DES_GPIO)
      begin
        oe_nxt[p] = !img_r[IDX_PIN0 + p][DIR_BIT];
        out_nxt[p] = img_r[IDX_PIN0 + p][OUT_VAL_BIT];
      end
    end
    unique case (img_r[IDX_PIN0][2:0])
      DES_ALT_DED: begin oe_nxt[0] = 1'b1; out_nxt[0] = suspend_in; end
      DES_ALT0: begin oe_nxt[0] = 1'b1; out_nxt[0] = uart_rx_act; end
      default: ;
    endcase
    unique case (img_r[IDX_PIN1][2:0])
      DES_ALT_DED: begin oe_nxt[1] = 1'b1; out_nxt[1] = clk_out_in; end
      DES_ALT0: ana_nxt[1] = 1'b1;
      DES_ALT1: begin oe_nxt[1] = 1'b1; out_nxt[1] = uart_tx_act; end
      default: ;
    endcase
    // pin two designation; analog output leaves digital driver off
    unique case (img_r[IDX_PIN2][2:0])
      DES_ALT_DED: begin oe_nxt[2] = 1'b1; out_nxt[2] = usb_cfg_in; end
      DES_ALT0: ana_nxt[2] = 1'b1;
      DES_ALT1: ana_nxt[2] = 1'b1;
      default: ;
    endcase
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= RD_IDLE;
      idx_r <= 6'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
      analog_sel <= 3'h0;
      p1_r <= 3'h0;
      p2_r <= 3'h0;
      gpio_in_val <= 3'h0;
      vref_level <= 2'h0;
      vref_internal <= 1'b0;
      usb_vid <= 16'h0000;
      usb_pid <= 16'h0000;
      usb_power_attr <= 8'h00;
      usb_current_ma <= 9'h000;
      int_flag <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      rd_data <= data_nxt;
      rd_valid <= (st_nxt == RD_SEND);
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
      analog_sel <= ana_nxt;
      p1_r <= pin_in;
      p2_r <= p1_r;
      gpio_in_val <= p2_r;
      vref_level <= img_r[IDX_CHIP][VREF_LVL_HI:VREF_LVL_LO];
      vref_internal <= img_r[IDX_CHIP][VREF_OPT_BIT];
      usb_vid <= {img_r[IDX_VID_HI], img_r[IDX_VID_LO]};
      usb_pid <= {img_r[IDX_PID_HI], img_r[IDX_PID_LO]};
      usb_power_attr <= img_r[IDX_PWR_ATTR];
      usb_current_ma <= {img_r[IDX_CURRENT], 1'b0};
      int_flag <= flag_w;
    end
  end
  assign rd_idx = idx_r;
  edge_detect u_edge (.clk(clk), .nrst(nrst), .neg_en(img_r[IDX_CHIP][NEG_EDGE_BIT]),
    .pos_en(img_r[IDX_CHIP][POS_EDGE_BIT]), .active(img_r[IDX_PIN1][2:0] == DES_ALT2),
    .pin_in(pin_in[1]), .flag_clr(flag_clr), .flag(flag_w));
  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_echo;
      (st_r == RD_IDLE && rd_req) |=> (rd_valid && rd_idx == 6'h00 && rd_data == ECHO_CODE)
        ##1 (rd_data == STATUS_OK);
  endproperty
  a_echo: assert property (p_echo) else $error("bad response header");
  property p_vid;
      (rd_valid && rd_idx == IDX_VID_LO) |-> (rd_data == usb_vid[7:0]) ##1 (rd_data == usb_vid[15:8]);
  endproperty
  a_vid: assert property (p_vid) else $error("vendor id order wrong");
  property p_pid;
      (rd_valid && rd_idx == IDX_PID_LO) |-> (rd_data == usb_pid[7:0]) ##1 (rd_data == usb_pid[15:8]);
  endproperty
  a_pid: assert property (p_pid) else $error("product id order wrong");
  property p_pwr;
      (rd_valid && rd_idx == IDX_PWR_ATTR) |-> rd_data == usb_power_attr;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power attributes mismatch");
  property p_ma;
      (rd_valid && rd_idx == IDX_CURRENT) |-> usb_current_ma == {rd_data, 1'b0};
  endproperty
  a_ma: assert property (p_ma) else $error("current not doubled");
  property p_pwd;
      (rd_valid && rd_idx >= IDX_PWD_FIRST && rd_idx <= IDX_PWD_LAST) |-> rd_data == img_r[rd_idx];
  endproperty
  a_pwd: assert property (p_pwd) else $error("password byte mismatch");
  property p_vref;
      (rd_valid && rd_idx == IDX_CHIP) |-> (rd_data[4:3] == vref_level && rd_data[2] == vref_internal);
  endproperty
  a_vref: assert property (p_vref) else $error("reference select mismatch");
  property p_vref_opt;
      $changed(img_r[IDX_CHIP][VREF_OPT_BIT]) |=> vref_internal == img_r[IDX_CHIP][VREF_OPT_BIT];
  endproperty
  a_vref_opt: assert property (p_vref_opt) else $error("reference option lag");
  property p_gpio_out;
      (img_r[IDX_PIN0][2:0] == DES_GPIO && !img_r[IDX_PIN0][DIR_BIT]) |=>
        (pin_oe[0] && pin_out[0] == $past(img_r[IDX_PIN0][OUT_VAL_BIT]));
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio output not driven");
  property p_gpio_in;
      (img_r[IDX_PIN2][2:0] == DES_GPIO && img_r[IDX_PIN2][DIR_BIT]) |=> !pin_oe[2];
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("input pin driven");
  property p_pin0;
      (img_r[IDX_PIN0][2:0] == DES_ALT_DED) |=> (pin_oe[0] && pin_out[0] == $past(suspend_in));
  endproperty
  a_pin0: assert property (p_pin0) else $error("suspend not routed");
  property p_pin1;
      (img_r[IDX_PIN1][2:0] == DES_ALT0) |=> (analog_sel[1] && !pin_oe[1]);
  endproperty
  a_pin1: assert property (p_pin1) else $error("analog one not selected");
  property p_pin2;
      (img_r[IDX_PIN2][2:0] == DES_ALT_DED) |=> (pin_oe[2] && pin_out[2] == $past(usb_cfg_in));
  endproperty
  a_pin2: assert property (p_pin2) else $error("usb configured not routed");
  property p_dc;
      (rd_valid && rd_idx >= IDX_PIN0 && rd_idx <= IDX_PIN2) |-> rd_data[7:5] == 3'h0;
  endproperty
  a_dc: assert property (p_dc) else $error("don't-care bits nonzero");
  c_readback: cover property (@(posedge clk) disable iff (!nrst) rd_valid && rd_idx == RESP_LAST);
  c_intflag: cover property (@(posedge clk) disable iff (!nrst) !int_flag ##1 int_flag);
  c_analog: cover property (@(posedge clk) disable iff (!nrst) analog_sel[2]);
endmodule : runtime_settings_pin_config

// ===== tb/host_resp_model.sv
/*
  Host-side model: collects one readback response byte per cycle.
  Assumes the device presents the frame from index 0 upward, one byte per clock.
*/
module host_resp_model
(
  // clock and control
  input wire logic clk,
  input wire logic clr,
  // response stream
  input wire logic rd_valid,
  input wire logic [5:0] rd_idx,
  input wire logic [7:0] rd_data,
  // collected frame
  output logic [7:0] resp [64],
  output int n_bytes,
  output logic order_err
);
  timeunit 1ns;
  timeprecision 1ps;
  // whole bytes kept, bench judges masked bits
  always @(posedge clk)
  begin
    if (clr)
    begin
      n_bytes <= 0;
      order_err <= 1'b0;
    end
    else if (rd_valid)
    begin
      resp[rd_idx] <= rd_data;
      n_bytes <= n_bytes + 1;
      // frame starts at zero and climbs
      if (rd_idx != n_bytes[5:0])
      begin
        order_err <= 1'b1;
      end
    end
  end
endmodule : host_resp_model

// ===== tb/runtime_settings_pin_config_tb.sv
/*
  Self-checking bench for the settings image and pin mux.
  Assumes inputs change on the falling edge and a host model collects readback.
*/
module runtime_settings_pin_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_req = 1'b0;
  logic flag_clr = 1'b0;
  logic clr = 1'b0;
  logic [5:0] wr_idx = 6'h00;
  logic [7:0] wr_data = 8'h00;
  logic [4:0] src = 5'h00;
  logic [2:0] pin_in = 3'h0;
  logic rd_valid, vref_internal, int_flag, order_err;
  logic [5:0] rd_idx;
  logic [7:0] rd_data, usb_power_attr;
  logic [1:0] vref_level;
  logic [15:0] usb_vid, usb_pid;
  logic [8:0] usb_current_ma;
  logic [2:0] analog_sel, pin_out, pin_oe, gpio_in_val;
  logic [7:0] resp [64];
  logic [7:0] img [64];
  logic [7:0] oe_tab [3] = '{8'h07, 8'h0B, 8'h03};
  logic [7:0] ana_tab [3] = '{8'h00, 8'h04, 8'h0C};
  int n_bytes;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  runtime_settings_pin_config DUT (.clk(clk), .nrst(nrst), .wr_en(wr_en), .wr_idx(wr_idx),
    .wr_data(wr_data), .rd_req(rd_req), .rd_valid(rd_valid), .rd_idx(rd_idx), .rd_data(rd_data),
    .suspend_in(src[0]), .uart_rx_act(src[1]), .uart_tx_act(src[2]), .clk_out_in(src[3]),
    .usb_cfg_in(src[4]), .flag_clr(flag_clr), .vref_level(vref_level), .vref_internal(vref_internal),
    .usb_vid(usb_vid), .usb_pid(usb_pid), .usb_power_attr(usb_power_attr),
    .usb_current_ma(usb_current_ma), .int_flag(int_flag), .analog_sel(analog_sel), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .gpio_in_val(gpio_in_val));

  host_resp_model host (.clk(clk), .clr(clr), .rd_valid(rd_valid), .rd_idx(rd_idx),
    .rd_data(rd_data), .resp(resp), .n_bytes(n_bytes), .order_err(order_err));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task summarize;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // strobe stays high so writes can run back to back; idle drops it
  task wr(input logic [5:0] idx, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_idx = idx;
    wr_data = d;
    if (idx == 6'h07)
      img[7] = d & 8'h7C;
    else if (idx >= 6'h16 && idx <= 6'h18)
      img[idx] = d & 8'h1F;
    else if (idx >= 6'h08 && idx <= 6'h15)
      img[idx] = d;
  endtask : wr

  task idle(input int n);
    @(negedge clk);
    wr_en = 1'b0;
    rd_req = 1'b0;
    flag_clr = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  task readback;
    int i;
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    rd_req = 1'b1;
    i = 0;
    while (n_bytes < 64 && i < 100)
    begin
      idle(0);
      i++;
    end
    idle(1);
    chk("rd_valid end", rd_valid, 16'h0000);
    chk("byte count", 16'(n_bytes), 16'h0040);
    chk("index order", order_err, 16'h0000);
    for (i = 0; i < 64; i++)
      chk("frame byte", resp[i], img[i]);
  endtask : readback

  task irq(input logic [7:0] b7, input logic from_lvl, input logic to_lvl, input logic exp);
    wr(6'h07, b7);
    pin_in[1] = from_lvl;
    idle(6);
    flag_clr = 1'b1;
    idle(3);
    chk("flag cleared", int_flag, 16'h0000);
    pin_in[1] = to_lvl;
    idle(8);
    chk("int_flag", int_flag, 16'(exp));
  endtask : irq

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      summarize;
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    int i, p, c;
    logic e;
    for (i = 0; i < 64; i++)
      img[i] = 8'h00;
    img[0] = 8'h61;
    for (i = 22; i < 25; i++)
      img[i] = 8'h08;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    readback;
    chk("pin_oe reset", pin_oe, 16'h0000);
    $display("test reset_image done");
    // junk in bits 7, 1 and 0 must not reach the image
    for (i = 0; i < 8; i++)
    begin
      wr(6'h07, {1'b1, 2'b00, 3'(i), 2'b11});
      idle(3);
      chk("vref_level", vref_level, 16'(i[2:1]));
      chk("vref_internal", vref_internal, 16'(i[0]));
    end
    readback;
    $display("test vref done");
    wr(6'h08, 8'h34);
    wr(6'h09, 8'h12);
    wr(6'h0A, 8'hCD);
    wr(6'h0B, 8'hAB);
    wr(6'h0C, 8'hA0);
    wr(6'h0D, 8'hFF);
    idle(3);
    chk("usb_vid", usb_vid, 16'h1234);
    chk("usb_pid", usb_pid, 16'hABCD);
    chk("usb_power_attr", usb_power_attr, 16'h00A0);
    chk("usb_current_ma", usb_current_ma, 16'h01FE);
    wr(6'h0D, 8'h32);
    idle(3);
    chk("usb_current_ma", usb_current_ma, 16'h0064);
    $display("test usb done");
    for (i = 0; i < 8; i++)
      wr(6'(14 + i), 8'(8'h81 + i));
    wr(6'h19, 8'hFF);
    wr(6'h05, 8'hFF);
    idle(2);
    readback;
    $display("test password done");
    for (p = 0; p < 3; p++)
    begin
      wr(6'(22 + p), 8'hF0);
      idle(3);
      chk("gpio oe", pin_oe[p], 16'h0001);
      chk("gpio out", pin_out[p], 16'h0001);
      wr(6'(22 + p), 8'h00);
      idle(3);
      chk("gpio out", pin_out[p], 16'h0000);
      wr(6'(22 + p), 8'hE8);
      pin_in = 3'h7;
      idle(5);
      chk("gpio in oe", pin_oe[p], 16'h0000);
      chk("gpio_in_val", gpio_in_val[p], 16'h0001);
      pin_in = 3'h0;
    end
    readback;
    $display("test gpio done");
    for (p = 0; p < 3; p++)
    begin
      for (c = 0; c < 8; c++)
      begin
        src = 5'h00;
        wr(6'(22 + p), {5'b00010, 3'(c)});
        idle(3);
        e = oe_tab[p][c];
        chk("mux oe", pin_oe[p], 16'(e));
        chk("analog_sel", analog_sel[p], 16'(ana_tab[p][c]));
        if (e)
          chk("mux out low", pin_out[p], 16'(c == 0));
        src = 5'h1F;
        idle(3);
        if (e)
          chk("mux out high", pin_out[p], 16'h0001);
      end
      wr(6'(22 + p), 8'h08);
    end
    src = 5'h00;
    $display("test designation done");
    wr(6'h17, 8'h0C);
    irq(8'h40, 1'b1, 1'b0, 1'b1);
    irq(8'h40, 1'b0, 1'b1, 1'b0);
    irq(8'h20, 1'b0, 1'b1, 1'b1);
    irq(8'h20, 1'b1, 1'b0, 1'b0);
    irq(8'h60, 1'b1, 1'b0, 1'b1);
    irq(8'h00, 1'b0, 1'b1, 1'b0);
    wr(6'h17, 8'h08);
    irq(8'h60, 1'b0, 1'b1, 1'b0);
    $display("test interrupt done");
    summarize;
  end
endmodule : runtime_settings_pin_config_tb
